//--- dssc_params.svh
// Constants for the divider start synchroniser configuration block.
`ifndef DSSC_PARAMS_SVH
`define DSSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Bus map (byte addresses)
// ----------------------------------------------------------------------------
`define DSSC_ADDR_W 4
`define DSSC_OFS_FRAME 4'h0
`define DSSC_OFS_STATUS 4'h4
`define DSSC_OFS_CTRL 4'h8

// ----------------------------------------------------------------------------
// Serial frame layout: low nibble is the register address
// ----------------------------------------------------------------------------
`define DSSC_FRAME_ADDR_W 4
`define DSSC_FRAME_ADDR 4'h9
`define DSSC_STORE_W 28
`define DSSC_STORE_RST 28'h0000000

// ----------------------------------------------------------------------------
// Storage bit positions
// ----------------------------------------------------------------------------
`define DSSC_B_RESYNC_DIS 9
`define DSSC_B_START_SKIP 10
`define DSSC_B_PRESENCE_BP 11
`define DSSC_B_LOCK_BP 12
`define DSSC_B_LOWFB_EN 13
`define DSSC_B_PRESET_INH 14
`define DSSC_B_AUX_DIS 20
`define DSSC_B_POS_X 22
`define DSSC_B_POS_Y 23
`define DSSC_B_NEG_X 24
`define DSSC_B_NEG_Y 25

// ----------------------------------------------------------------------------
// Logic-level output modes, written as {x, y}
// ----------------------------------------------------------------------------
`define DSSC_MODE_ACTIVE 2'b00
`define DSSC_MODE_FLOAT 2'b01
`define DSSC_MODE_INVERT 2'b10
`define DSSC_MODE_LOW 2'b11

// Control register bit that reloads the stored default.
`define DSSC_B_RELOAD 0

`endif

//--- dssc_pkg.sv
// Types shared by the divider start synchroniser configuration block.
package dssc_pkg;

    // Pin-level inputs that arrive from outside the clock domain.
    typedef struct packed {
        logic start_req;
        logic osc_present;
        logic aux_present;
        logic pll_lock;
        logic low_freq_det;
        logic hold_active_low;
        logic global_test_mode_enable;
    } dssc_pins_s;

    // Logic-level drive for the two pins of output 9.
    typedef struct packed {
        logic pos_data;
        logic pos_oe;
        logic neg_data;
        logic neg_oe;
    } dssc_out9_s;

endpackage

//--- dssc_core.sv
// Divider start synchroniser, preset, aux buffer and output 9 mode control.
//
// Summary of operation
// - Resync disable ignored without global test mode.
// - Test mode: disable bit bypasses divider resync.
// - Skip bit bypasses oscillator start synchronisation.
// - Start waits for oscillator/aux presence unless bypassed.
// - Start waits for first lock unless bypassed.
// - Low feedback frequency enable starts sync logic.
// - Inhibit low: hold low presets M divider.
// - Inhibit high: hold never presets M divider.
// - Aux disable bit turns aux buffer off.
// - Positive output 9 pin follows mode field.
// - Negative pin has own same-coded mode field.
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dssc_params.svh"

module dssc_core
(
    input wire logic sys_clk, // 100 MHz system clock.
    input wire logic resetn, // Asynchronous active-low reset.
    input wire dssc_pkg::dssc_pins_s pins, // Raw pin levels, synchronised here.
    input wire logic [`DSSC_STORE_W-1:0] nvm_cfg, // Stored power-up defaults.
    input wire logic feedback_mux_select, // Feedback mux select from the core.
    input wire logic output_mux_select, // Output mux select from the core.
    input wire logic out9_src, // Logic-level data for output 9.
    input wire logic [`DSSC_ADDR_W-1:0] avs_address, // Avalon byte address.
    input wire logic avs_read, // Avalon read request.
    input wire logic avs_write, // Avalon write request.
    input wire logic [31:0] avs_writedata, // Avalon write data.
    output logic [31:0] avs_readdata, // Avalon read data.
    output logic avs_waitrequest, // Avalon wait request.
    output logic start_out, // Resynchronised divider start.
    output logic m_div_preset, // Preset request to the M divider.
    output logic aux_buf_en, // Auxiliary input buffer enable.
    output dssc_pkg::dssc_out9_s out9 // Output 9 pin drive.
);
    import dssc_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    dssc_pins_s pins_m_r;
    dssc_pins_s pins_s_r;

    // Release reset through two flops so every flop leaves reset together.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // Two-flop synchroniser; only the second stage is read by logic.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_m_r <= '0;
            pins_s_r <= '0;
            pins_m_r.hold_active_low <= 1'b1; // Idle level, so no preset pulse follows reset.
            pins_s_r.hold_active_low <= 1'b1; // Idle level, so no preset pulse follows reset.
        end
        else
        begin
            pins_m_r <= pins;
            pins_s_r <= pins_m_r;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------------------
    logic [`DSSC_STORE_W-1:0] cfg_r;
    logic load_pend_r;
    logic ack_r;
    logic bus_hit;
    logic frame_wr;
    logic reload_wr;

    // Decodes a word-aligned byte offset against the request address.
    function automatic logic addr_is(input logic [`DSSC_ADDR_W-1:0] a,
                                     input logic [`DSSC_ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    assign bus_hit = avs_write && !ack_r;
    assign frame_wr = bus_hit && addr_is(avs_address, `DSSC_OFS_FRAME)
                      && (avs_writedata[`DSSC_FRAME_ADDR_W-1:0] == `DSSC_FRAME_ADDR);
    assign reload_wr = bus_hit && addr_is(avs_address, `DSSC_OFS_CTRL)
                       && avs_writedata[`DSSC_B_RELOAD];

    // Default load is requested once after reset and again on reload.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            load_pend_r <= 1'b1;
        else
            load_pend_r <= reload_wr;
    end

    // Storage takes the stored default or a software frame.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= `DSSC_STORE_RST;
        else if (load_pend_r)
            cfg_r <= nvm_cfg;
        else if (frame_wr)
            cfg_r <= avs_writedata[31:`DSSC_FRAME_ADDR_W];
    end

    // ------------------------------------------------------------------------
    // Start gating
    // ------------------------------------------------------------------------
    logic first_lock_r;
    logic low_fb_go;
    logic presence_ok;
    logic lock_ok;
    logic start_gate;
    logic gated_start;

    // Remember the first lock indication until reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            first_lock_r <= 1'b0;
        else if (pins_s_r.pll_lock)
            first_lock_r <= 1'b1;
    end

    // Combine presence, lock and low-frequency conditions.
    always_comb
    begin
        low_fb_go = cfg_r[`DSSC_B_LOWFB_EN] && pins_s_r.low_freq_det;
        presence_ok = cfg_r[`DSSC_B_PRESENCE_BP] || pins_s_r.osc_present
                      || pins_s_r.aux_present;
        lock_ok = cfg_r[`DSSC_B_LOCK_BP] || first_lock_r;
        start_gate = low_fb_go || (presence_ok && lock_ok);
        gated_start = pins_s_r.start_req && start_gate;
    end

    // ------------------------------------------------------------------------
    // Start resynchronisation stages
    // ------------------------------------------------------------------------
    logic [1:0] osc_sync_r;
    logic [1:0] div_sync_r;
    logic osc_stage;
    logic div_bypass;
    logic div_stage;

    // Oscillator stage and divider stage, each bypassable.
    always_comb
    begin
        osc_stage = cfg_r[`DSSC_B_START_SKIP] ? gated_start : osc_sync_r[1];
        div_bypass = pins_s_r.global_test_mode_enable
                     && cfg_r[`DSSC_B_RESYNC_DIS];
        div_stage = div_bypass ? osc_stage : div_sync_r[1];
    end

    // Shift registers that retime the start toward the dividers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sync_r <= 2'h0;
            div_sync_r <= 2'h0;
            start_out <= 1'b0;
        end
        else
        begin
            osc_sync_r <= {osc_sync_r[0], gated_start};
            div_sync_r <= {div_sync_r[0], osc_stage};
            start_out <= div_stage;
        end
    end

    // ------------------------------------------------------------------------
    // Preset, aux buffer and output 9 drive
    // ------------------------------------------------------------------------
    // Maps one mode field and the source bit to pin data and enable.
    function automatic logic [1:0] mode_drive(input logic [1:0] mode, input logic src);
        case (mode)
            `DSSC_MODE_ACTIVE: mode_drive = {src, 1'b1};
            `DSSC_MODE_INVERT: mode_drive = {~src, 1'b1};
            `DSSC_MODE_LOW: mode_drive = {1'b0, 1'b1};
            default: mode_drive = {1'b0, 1'b0};
        endcase
    endfunction

    // Registered preset, buffer enable and pin drive.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            m_div_preset <= 1'b0;
            aux_buf_en <= 1'b0;
            out9 <= '0;
        end
        else
        begin
            m_div_preset <= !cfg_r[`DSSC_B_PRESET_INH]
                            && !pins_s_r.hold_active_low;
            aux_buf_en <= !cfg_r[`DSSC_B_AUX_DIS]
                          && (feedback_mux_select || output_mux_select);
            {out9.pos_data, out9.pos_oe} <= mode_drive(
                {cfg_r[`DSSC_B_POS_X], cfg_r[`DSSC_B_POS_Y]}, out9_src);
            {out9.neg_data, out9.neg_oe} <= mode_drive(
                {cfg_r[`DSSC_B_NEG_X], cfg_r[`DSSC_B_NEG_Y]}, out9_src);
        end
    end

    // ------------------------------------------------------------------------
    // Avalon-MM slave: one wait state, registered read data
    // ------------------------------------------------------------------------
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    // Acknowledge each request one cycle after it appears.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read || avs_write) && !ack_r;
    end

    // Read data is captured on the first cycle; unmapped reads give zero.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack_r)
        begin
            if (addr_is(avs_address, `DSSC_OFS_FRAME))
                avs_readdata <= {cfg_r, `DSSC_FRAME_ADDR};
            else if (addr_is(avs_address, `DSSC_OFS_STATUS))
                avs_readdata <= {27'h0, start_out, div_bypass, start_gate,
                                 first_lock_r, load_pend_r};
            else
                avs_readdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    no_test_bypass_a: assert property (
        !pins_s_r.global_test_mode_enable |=> start_out == $past(div_sync_r[1]))
        else $error("Resync disable acted outside test mode.");
    test_bypass_a: assert property (
        div_bypass && cfg_r[`DSSC_B_START_SKIP] |=> start_out == $past(gated_start))
        else $error("Divider resync not bypassed in test mode.");
    osc_sync_lat_a: assert property (
        !cfg_r[`DSSC_B_START_SKIP] && div_bypass && $rose(gated_start) ##1 $stable(cfg_r)
        |=> !start_out ##1 start_out)
        else $error("Oscillator start stage latency wrong.");
    skip_bypass_a: assert property (
        cfg_r[`DSSC_B_START_SKIP] |=> div_sync_r[0] == $past(gated_start))
        else $error("Start skip did not bypass the oscillator stage.");
    presence_gate_a: assert property (
        !cfg_r[`DSSC_B_PRESENCE_BP] && !pins_s_r.osc_present && !pins_s_r.aux_present
        && !(cfg_r[`DSSC_B_LOWFB_EN] && pins_s_r.low_freq_det) |-> !start_gate)
        else $error("Start gate open without clock presence.");
    lock_gate_a: assert property (
        !cfg_r[`DSSC_B_LOCK_BP] && !first_lock_r
        && !(cfg_r[`DSSC_B_LOWFB_EN] && pins_s_r.low_freq_det) |-> !start_gate)
        else $error("Start gate open before first lock.");
    low_fb_a: assert property (
        cfg_r[`DSSC_B_LOWFB_EN] && pins_s_r.low_freq_det |-> start_gate)
        else $error("Low feedback frequency did not start sync.");
    preset_on_a: assert property (
        !cfg_r[`DSSC_B_PRESET_INH] && !pins_s_r.hold_active_low |=> m_div_preset)
        else $error("Hold did not preset the M divider.");
    preset_off_a: assert property (
        cfg_r[`DSSC_B_PRESET_INH] |=> !m_div_preset)
        else $error("M divider preset while inhibited.");
    aux_off_a: assert property (
        cfg_r[`DSSC_B_AUX_DIS] |=> !aux_buf_en)
        else $error("Aux buffer enabled while disabled.");
    aux_on_a: assert property (
        !cfg_r[`DSSC_B_AUX_DIS] && (feedback_mux_select || output_mux_select)
        |=> aux_buf_en)
        else $error("Aux buffer not enabled by the mux selects.");
    pos_low_a: assert property (
        cfg_r[`DSSC_B_POS_X] && cfg_r[`DSSC_B_POS_Y] |=> out9.pos_oe && !out9.pos_data)
        else $error("Positive pin not held low.");
    neg_inv_a: assert property (
        cfg_r[`DSSC_B_NEG_X] && !cfg_r[`DSSC_B_NEG_Y]
        |=> out9.neg_oe && out9.neg_data == !$past(out9_src))
        else $error("Negative pin not inverted.");
    frame_store_a: assert property (
        frame_wr && !load_pend_r |=> cfg_r == $past(avs_writedata[31:`DSSC_FRAME_ADDR_W]))
        else $error("Frame write not stored at bit minus four.");
    reload_a: assert property (
        reload_wr |=> ##1 cfg_r == $past(nvm_cfg))
        else $error("Reload did not restore stored defaults.");

    start_pass_c: cover property ($rose(start_out));
    gate_closed_c: cover property (pins_s_r.start_req && !start_gate);
    test_bypass_c: cover property (div_bypass && gated_start);
    low_fb_c: cover property (low_fb_go && !presence_ok);
    frame_wr_c: cover property (frame_wr);
endmodule

//--- dssc_tb.sv
// Self-checking bench for the divider start synchroniser configuration block.
`timescale 1ns/1ps
`include "dssc_params.svh"

module testbench;
    import dssc_pkg::*;

    // ------------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    dssc_pins_s pins = '0;
    logic [27:0] nvm_cfg = 28'h5a3c6e1;
    logic feedback_mux_select = 1'b0;
    logic output_mux_select = 1'b0;
    logic out9_src = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic start_out;
    logic m_div_preset;
    logic aux_buf_en;
    dssc_out9_s out9;
    logic [31:0] rd;
    int fails = 0;
    int num_checks = 0;

    dssc_core u_dut (.sys_clk(sys_clk), .resetn(resetn), .pins(pins), .nvm_cfg(nvm_cfg),
        .feedback_mux_select(feedback_mux_select), .output_mux_select(output_mux_select),
        .out9_src(out9_src), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .start_out(start_out),
        .m_div_preset(m_div_preset), .aux_buf_en(aux_buf_en), .out9(out9));

    // The clock toggles every half period of 5 ns.
    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus transfer; the request is held until waitrequest is seen low.
    task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 20)
        begin
            fails++;
            $display("[FAIL] %0t bus transfer timed out", $time);
            end_sim();
        end
    endtask

    // Writes the storage word through the frame register and reads it back.
    task automatic setc(input logic [27:0] c);
        avs_xfer(1'b1, `DSSC_OFS_FRAME, {c, `DSSC_FRAME_ADDR});
        avs_xfer(1'b0, `DSSC_OFS_FRAME, 32'h0);
        chk(rd, {c, `DSSC_FRAME_ADDR});
    endtask

    // Raises start and measures the edges until start_out rises; 0 means never.
    task automatic run_start(input int exp);
        int got;
        got = 0;
        repeat (4) @(posedge sys_clk);
        pins.start_req <= 1'b1;
        for (int n = 1; n <= 12; n++)
        begin
            @(posedge sys_clk);
            #1;
            if (start_out === 1'b1 && got == 0)
                got = n;
        end
        chk(32'(got), 32'(exp));
        @(posedge sys_clk);
        pins.start_req <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic [1:0] m;
        pins.hold_active_low = 1'b1;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        // Stored defaults, frame mapping, bad address nibble, unmapped place, reload.
        avs_xfer(1'b0, `DSSC_OFS_FRAME, 32'h0);
        chk(rd, {nvm_cfg, 4'h9});
        setc(28'h0001800);
        avs_xfer(1'b1, `DSSC_OFS_FRAME, 32'hfffffff3);
        avs_xfer(1'b1, 4'hc, 32'hffffffff);
        avs_xfer(1'b0, `DSSC_OFS_FRAME, 32'h0);
        chk(rd, 32'h00018009);
        avs_xfer(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        avs_xfer(1'b1, `DSSC_OFS_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        avs_xfer(1'b0, `DSSC_OFS_FRAME, 32'h0);
        chk(rd, {nvm_cfg, 4'h9});
        // Start path: presence and lock bypassed, stages added or skipped.
        setc(28'h0001800);
        run_start(7);
        setc(28'h0001c00);
        run_start(5);
        setc(28'h0001a00);
        run_start(7);
        pins.global_test_mode_enable <= 1'b1;
        run_start(5);
        setc(28'h0001e00);
        run_start(3);
        avs_xfer(1'b0, `DSSC_OFS_STATUS, 32'h0);
        chk(rd, 32'h0000000c);
        pins.global_test_mode_enable <= 1'b0;
        // Clock presence gating.
        setc(28'h0001000);
        run_start(0);
        pins.osc_present <= 1'b1;
        run_start(7);
        pins.osc_present <= 1'b0;
        pins.aux_present <= 1'b1;
        run_start(7);
        // Wait for the first lock, which then stays remembered.
        setc(28'h0000800);
        run_start(0);
        pins.pll_lock <= 1'b1;
        repeat (4) @(posedge sys_clk);
        pins.pll_lock <= 1'b0;
        run_start(7);
        // Low feedback frequency opens the start on its own.
        pins.aux_present <= 1'b0;
        pins.low_freq_det <= 1'b1;
        setc(28'h0002000);
        run_start(7);
        setc(28'h0000000);
        run_start(0);
        // Divider preset by the hold input, unless inhibited.
        pins.hold_active_low <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk(32'(m_div_preset), 32'h1);
        pins.hold_active_low <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(32'(m_div_preset), 32'h0);
        setc(28'h0004000);
        pins.hold_active_low <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk(32'(m_div_preset), 32'h0);
        // Auxiliary buffer follows the mux selects unless disabled.
        chk(32'(aux_buf_en), 32'h0);
        feedback_mux_select <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(aux_buf_en), 32'h1);
        feedback_mux_select <= 1'b0;
        output_mux_select <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(aux_buf_en), 32'h1);
        setc(28'h0100000);
        repeat (3) @(posedge sys_clk);
        chk(32'(aux_buf_en), 32'h0);
        // Output 9 modes on both pins, each pin with a different mode at once.
        for (int i = 0; i < 8; i++)
        begin
            m = 2'(i >> 1);
            setc({2'b00, ~m[0], ~m[1], m[0], m[1], 22'h0});
            out9_src <= i[0];
            repeat (3) @(posedge sys_clk);
            chk({30'h0, out9.pos_data, out9.pos_oe},
                {30'h0, (m == 2'b00) ? i[0] : (m == 2'b10) ? ~i[0] : 1'b0, m != 2'b01});
            chk({30'h0, out9.neg_data, out9.neg_oe},
                {30'h0, (m == 2'b11) ? i[0] : (m == 2'b01) ? ~i[0] : 1'b0, m != 2'b10});
        end
        end_sim();
    end
endmodule
